// [rtl/tmas_defs.vh]
`ifndef TMAS_DEFS_VH
`define TMAS_DEFS_VH

// register pointer values, read side
`define TMAS_RD_LOCAL_VAL 8'h00
`define TMAS_RD_REMOTE_VAL 8'h01
`define TMAS_RD_STATUS 8'h02
`define TMAS_RD_CONFIG 8'h03
`define TMAS_RD_LOCAL_HIGH 8'h05
`define TMAS_RD_LOCAL_LOW 8'h06
`define TMAS_RD_REMOTE_HIGH 8'h07
`define TMAS_RD_REMOTE_LOW 8'h08

// register pointer values, write side
`define TMAS_WR_CONFIG 8'h09
`define TMAS_WR_LOCAL_HIGH 8'h0b
`define TMAS_WR_LOCAL_LOW 8'h0c
`define TMAS_WR_REMOTE_HIGH 8'h0d
`define TMAS_WR_REMOTE_LOW 8'h0e
`define TMAS_WR_ONE_SHOT 8'h0f

// configuration and status fields
`define TMAS_CFG_STANDBY_BIT 6
`define TMAS_ST_LOCAL_HIGH_BIT 6
`define TMAS_ST_LOCAL_LOW_BIT 5
`define TMAS_ST_REMOTE_HIGH_BIT 4
`define TMAS_ST_REMOTE_LOW_BIT 3
`define TMAS_ST_OPEN_BIT 2

// reset values
`define TMAS_CONFIG_RST 8'h00
`define TMAS_HIGH_LIMIT_RST 8'h7f
`define TMAS_LOW_LIMIT_RST 8'h00
`define TMAS_VALUE_RST 8'h00

// bus constants
`define TMAS_ALERT_READ 8'h19
`define TMAS_BITS_PER_BYTE 4'd8
`define TMAS_UNDER_RANGE_CODE 8'h80

// timing
`define TMAS_CONV_GAP 16'd4000
`define TMAS_STRAP_WAIT 2'd3

`endif

// [rtl/tmas_monitor.v]
`default_nettype none

`include "tmas_defs.vh"

module tmas_monitor #(
  parameter [15:0] CONV_GAP = `TMAS_CONV_GAP
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // two-wire bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o,
  // alarm pin
  output wire alert_o,
  output wire alert_oe_n_o,
  // straps and standby pin
  input wire [6:0] dev_addr_i,
  input wire sleep_request_n_i,
  // converter side
  input wire open_fault_i,
  input wire conv_done_i,
  input wire [7:0] local_temp_i,
  input wire [7:0] remote_temp_i,
  input wire remote_under_i,
  output wire conv_start_o,
  output wire conv_abort_o,
  output wire standby_o
);

  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_ADDR = 6'b000010;
  localparam [5:0] S_ACK = 6'b000100;
  localparam [5:0] S_WDATA = 6'b001000;
  localparam [5:0] S_RDATA = 6'b010000;
  localparam [5:0] S_RACK = 6'b100000;

  localparam [1:0] C_IDLE = 2'b01;
  localparam [1:0] C_RUN = 2'b10;

  // synchronisers
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  reg sleep_m_q, sleep_s_q;
  reg open_m_q, open_s_q;
  reg [6:0] addr_m_q, addr_s_q, dev_addr_q;
  reg [1:0] strap_cnt_q;

  // bus engine
  reg [5:0] st_q;
  reg [7:0] shift_q, tx_q, ptr_q;
  reg [3:0] cnt_q;
  reg drive_q, rw_q, ara_q, first_q, wr_stb_q, ara_ok_q;

  // registers and conversion
  reg [7:0] cfg_q, status_q, local_val_q, remote_val_q;
  reg [7:0] local_high_q, local_low_q, remote_high_q, remote_low_q;
  reg [1:0] cst_q;
  reg [15:0] gap_q;
  reg start_q, abort_q, oneshot_pend_q, oneshot_run_q, alert_q;

  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire byte_done = (cnt_q == `TMAS_BITS_PER_BYTE);

  wire hw_standby = ~sleep_s_q;
  wire standby = hw_standby | cfg_q[`TMAS_CFG_STANDBY_BIT];
  wire [7:0] remote_now = remote_under_i ? `TMAS_UNDER_RANGE_CODE : remote_temp_i;
  wire alarm_cause = status_q[`TMAS_ST_LOCAL_HIGH_BIT] | status_q[`TMAS_ST_LOCAL_LOW_BIT] |
                     status_q[`TMAS_ST_REMOTE_HIGH_BIT] | status_q[`TMAS_ST_REMOTE_LOW_BIT] |
                     status_q[`TMAS_ST_OPEN_BIT];

  // signed two's-complement less-than
  function lt_s;
    input [7:0] a;
    input [7:0] b;
    begin
      lt_s = $signed(a) < $signed(b);
    end
  endfunction

  // read data for a pointer value
  function [7:0] rd_mux;
    input [7:0] p;
    begin
      case (p)
        `TMAS_RD_LOCAL_VAL: rd_mux = local_val_q;
        `TMAS_RD_REMOTE_VAL: rd_mux = remote_val_q;
        `TMAS_RD_STATUS: rd_mux = status_q;
        `TMAS_RD_CONFIG: rd_mux = cfg_q;
        `TMAS_RD_LOCAL_HIGH: rd_mux = local_high_q;
        `TMAS_RD_LOCAL_LOW: rd_mux = local_low_q;
        `TMAS_RD_REMOTE_HIGH: rd_mux = remote_high_q;
        `TMAS_RD_REMOTE_LOW: rd_mux = remote_low_q;
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // pin synchronisers and strap capture
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      sleep_m_q <= 1'b1;
      sleep_s_q <= 1'b1;
      open_m_q <= 1'b0;
      open_s_q <= 1'b0;
      addr_m_q <= 7'h00;
      addr_s_q <= 7'h00;
      dev_addr_q <= 7'h00;
      strap_cnt_q <= 2'd0;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      sleep_m_q <= sleep_request_n_i;
      sleep_s_q <= sleep_m_q;
      open_m_q <= open_fault_i;
      open_s_q <= open_m_q;
      addr_m_q <= dev_addr_i;
      addr_s_q <= addr_m_q;
      if (strap_cnt_q != `TMAS_STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'd1;
        dev_addr_q <= addr_s_q;
      end
    end
  end

  // two-wire slave engine, runs whatever the standby state
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 4'd0;
      drive_q <= 1'b0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      first_q <= 1'b1;
      wr_stb_q <= 1'b0;
      ara_ok_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      ara_ok_q <= 1'b0;
      if (bus_start) begin
        st_q <= S_ADDR;
        cnt_q <= 4'd0;
        drive_q <= 1'b0;
        ara_q <= 1'b0;
        first_q <= 1'b1;
      end else if (bus_stop) begin
        st_q <= S_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'd1;
            end else if (scl_fall && byte_done) begin
              if (shift_q[7:1] == dev_addr_q) begin
                drive_q <= 1'b1;
                rw_q <= shift_q[0];
                tx_q <= rd_mux(ptr_q);
                st_q <= S_ACK;
              end else if (shift_q == `TMAS_ALERT_READ && alert_q) begin
                drive_q <= 1'b1;
                rw_q <= 1'b1;
                ara_q <= 1'b1;
                tx_q <= {dev_addr_q, 1'b0};
                st_q <= S_ACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'd0;
              if (rw_q) begin
                drive_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                st_q <= S_RDATA;
              end else begin
                drive_q <= 1'b0;
                st_q <= S_WDATA;
              end
            end
          end
          S_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'd1;
            end else if (scl_fall && byte_done) begin
              if (first_q) begin
                ptr_q <= shift_q;
              end else begin
                wr_stb_q <= 1'b1;
              end
              first_q <= 1'b0;
              drive_q <= 1'b1;
              st_q <= S_ACK;
            end
          end
          S_RDATA: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'd1;
              if (!drive_q && !sda_s_q) begin
                st_q <= S_IDLE;
              end
            end else if (scl_fall) begin
              if (byte_done) begin
                drive_q <= 1'b0;
                ara_ok_q <= ara_q;
                ara_q <= 1'b0;
                st_q <= S_RACK;
              end else begin
                drive_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              if (!sda_s_q) begin
                tx_q <= rd_mux(ptr_q);
                st_q <= S_ACK;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          default: begin
            st_q <= S_IDLE;
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // register writes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= `TMAS_CONFIG_RST;
      local_high_q <= `TMAS_HIGH_LIMIT_RST;
      local_low_q <= `TMAS_LOW_LIMIT_RST;
      remote_high_q <= `TMAS_HIGH_LIMIT_RST;
      remote_low_q <= `TMAS_LOW_LIMIT_RST;
    end else if (wr_stb_q) begin
      case (ptr_q)
        `TMAS_WR_CONFIG: cfg_q <= shift_q;
        `TMAS_WR_LOCAL_HIGH: local_high_q <= shift_q;
        `TMAS_WR_LOCAL_LOW: local_low_q <= shift_q;
        `TMAS_WR_REMOTE_HIGH: remote_high_q <= shift_q;
        `TMAS_WR_REMOTE_LOW: remote_low_q <= shift_q;
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // conversion sequencing, status and alarm latch
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cst_q <= C_IDLE;
      gap_q <= 16'd0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      oneshot_pend_q <= 1'b0;
      oneshot_run_q <= 1'b0;
      status_q <= 8'h00;
      local_val_q <= `TMAS_VALUE_RST;
      remote_val_q <= `TMAS_VALUE_RST;
      alert_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
      // one-shot write, data discarded
      if (wr_stb_q && ptr_q == `TMAS_WR_ONE_SHOT && cfg_q[`TMAS_CFG_STANDBY_BIT] && !hw_standby) begin
        oneshot_pend_q <= 1'b1;
      end else if (hw_standby) begin
        oneshot_pend_q <= 1'b0;
      end
      case (cst_q)
        C_IDLE: begin
          if ((!standby && gap_q == CONV_GAP) || (oneshot_pend_q && !hw_standby)) begin
            start_q <= 1'b1;
            status_q[`TMAS_ST_OPEN_BIT] <= open_s_q;
            oneshot_run_q <= standby;
            oneshot_pend_q <= 1'b0;
            gap_q <= 16'd0;
            cst_q <= C_RUN;
          end else if (gap_q != CONV_GAP) begin
            gap_q <= gap_q + 16'd1;
          end
        end
        C_RUN: begin
          if (hw_standby || (cfg_q[`TMAS_CFG_STANDBY_BIT] && !oneshot_run_q)) begin
            abort_q <= 1'b1;
            oneshot_run_q <= 1'b0;
            cst_q <= C_IDLE;
          end else if (conv_done_i) begin
            local_val_q <= local_temp_i;
            remote_val_q <= remote_now;
            status_q[`TMAS_ST_LOCAL_HIGH_BIT] <= lt_s(local_high_q, local_temp_i);
            status_q[`TMAS_ST_LOCAL_LOW_BIT] <= lt_s(local_temp_i, local_low_q);
            status_q[`TMAS_ST_REMOTE_HIGH_BIT] <= lt_s(remote_high_q, remote_now);
            status_q[`TMAS_ST_REMOTE_LOW_BIT] <= lt_s(remote_now, remote_low_q);
            oneshot_run_q <= 1'b0;
            cst_q <= C_IDLE;
          end
        end
        default: cst_q <= C_IDLE;
      endcase
      // cause keeps alarm set; response clears only when cause gone
      if (alarm_cause) begin
        alert_q <= 1'b1;
      end else if (ara_ok_q) begin
        alert_q <= 1'b0;
      end
    end
  end

  // open-drain pins: only pull low or float
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_q;
  assign alert_o = 1'b0;
  assign alert_oe_n_o = ~alert_q;
  assign conv_start_o = start_q;
  assign conv_abort_o = abort_q;
  assign standby_o = standby;

endmodule // tmas_monitor

`default_nettype wire

// [verif/tmas_monitor_sva.sv]
`default_nettype none
module tmas_monitor_chk #(
  parameter [15:0] CONV_GAP = 16'd4000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic alert_o,
  input wire logic alert_oe_n_o,
  input wire logic sleep_request_n_i,
  // converter side
  input wire logic open_fault_i,
  input wire logic conv_done_i,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic standby_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sda_only_low_a: assert property (sda_o == 1'b0) else $error("data pin value not low");
  alert_only_low_a: assert property (alert_o == 1'b0) else $error("alarm pin value not low");
  pin_standby_a: assert property (!sleep_request_n_i [*4] |-> standby_o)
    else $error("standby level missing with pin low");
  pin_no_start_a: assert property (!sleep_request_n_i [*4] |-> !conv_start_o)
    else $error("conversion started with pin low");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o) else $error("start pulse too long");
  abort_standby_a: assert property (conv_abort_o |-> $past(standby_o))
    else $error("abort without standby");
  open_alert_a: assert property (conv_done_i && open_fault_i && $past(open_fault_i, 16) |-> ##[1:3] !alert_oe_n_o)
    else $error("open diode did not raise alarm");
  alert_release_a: assert property ($rose(alert_oe_n_o) |-> !scl_i)
    else $error("alarm released outside alert read");
endmodule // tmas_monitor_chk
`default_nettype wire

// [verif/tmas_smb_master.sv]
`default_nettype none
module tmas_smb_master (
  // clock
  input wire logic clk_i,
  // bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // data changes only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    hc(8);
    scl_o <= 1'b1;
    hc(10);
    r = sda_i;
    scl_o <= 1'b0;
    hc(6);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    scl_o <= 1'b1;
    hc(10);
    sda_o <= 1'b0;
    hc(10);
    scl_o <= 1'b0;
    hc(6);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hc(8);
    scl_o <= 1'b1;
    hc(10);
    sda_o <= 1'b1;
    hc(10);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask
endmodule // tmas_smb_master
`default_nettype wire

// [verif/tmas_monitor_test.sv]
`default_nettype none
`include "tmas_defs.vh"
module tmas_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [6:0] ADDR = 7'h4c;
  logic clk_i = 0, rst_n_i = 0, sleep_n = 1, open_f = 0, done = 0, under = 0, ack;
  logic [7:0] lt = 8'h00, rt = 8'h00, d, last;
  logic [15:0] lf = 16'd15159;
  int err_total = 0, comparisons = 0, nstart = 0, ndone = 0, nabort = 0, cnt = 0, k, a0;
  wire scl, m_sda, sda_oe_n, sda_d, alert_oe_n, alert_d, start, abort, sleep_request_n;
  wire sda = m_sda & (sda_oe_n | sda_d);
  wire alrt = alert_oe_n | alert_d;
  tmas_smb_master u_tmas_smb_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  tmas_monitor #(.CONV_GAP(16'd20)) u_tmas_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .alert_o(alert_d), .alert_oe_n_o(alert_oe_n), .dev_addr_i(ADDR),
    .sleep_request_n_i(sleep_n), .open_fault_i(open_f), .conv_done_i(done), .local_temp_i(lt),
    .remote_temp_i(rt), .remote_under_i(under), .conv_start_o(start), .conv_abort_o(abort), .standby_o(sleep_request_n));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    done <= 1'b0;
    if (start) nstart++;
    if (abort) begin
      nabort++;
      cnt <= 0;
    end else if (start) cnt <= 12;
    else if (cnt != 0) begin
      cnt <= cnt - 1;
      done <= (cnt == 1);
      if (cnt == 1) ndone++;
    end
  end
  function automatic [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic hc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(string n, logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] p, logic [7:0] v, bit two);
    u_tmas_smb_master.start();
    u_tmas_smb_master.wbyte({ADDR, 1'b0}, ack);
    chk("address ack", {7'd0, ack}, 8'h01);
    u_tmas_smb_master.wbyte(p, ack);
    if (two) u_tmas_smb_master.wbyte(v, ack);
    u_tmas_smb_master.stop();
  endtask
  task automatic rd(logic [7:0] p, logic [7:0] e, string n);
    wr(p, 8'h00, 0);
    u_tmas_smb_master.start();
    u_tmas_smb_master.wbyte({ADDR, 1'b1}, ack);
    u_tmas_smb_master.rbyte(d, 1'b1);
    u_tmas_smb_master.stop();
    chk(n, d, e);
  endtask
  task automatic ara(logic a);
    u_tmas_smb_master.start();
    u_tmas_smb_master.wbyte(`TMAS_ALERT_READ, ack);
    chk("alert read ack", {7'd0, ack}, {7'd0, a});
    if (ack) u_tmas_smb_master.rbyte(d, 1'b1);
    if (ack) chk("alert read address", d, {ADDR, 1'b0});
    u_tmas_smb_master.stop();
    hc(4);
  endtask
  // alert read where a lower address pulls the first data bit low
  task automatic lose_arb;
    u_tmas_smb_master.start();
    u_tmas_smb_master.wbyte(`TMAS_ALERT_READ, ack);
    chk("contest ack", {7'd0, ack}, 8'h01);
    u_tmas_smb_master.bit_io(1'b0, d[7]);
    for (int i = 6; i >= 0; i--) u_tmas_smb_master.bit_io(1'b1, d[i]);
    u_tmas_smb_master.bit_io(1'b1, ack);
    u_tmas_smb_master.stop();
    chk("lost device quiet", d, 8'h7f);
    hc(4);
  endtask
  task automatic wcnt(bit s, int n);
    k = (s ? nstart : ndone) + n;
    for (int i = 0; i < 4000 && (s ? nstart : ndone) < k; i++) hc(1);
    if ((s ? nstart : ndone) < k) chk("timeout", 8'h00, 8'h01);
    if ((s ? nstart : ndone) < k) report_and_stop();
    hc(4);
  endtask
  initial begin
    hc(3);
    rst_n_i <= 1'b1;
    hc(6);
    rd(`TMAS_RD_CONFIG, `TMAS_CONFIG_RST, "config reset");
    rd(`TMAS_RD_REMOTE_HIGH, `TMAS_HIGH_LIMIT_RST, "remote high reset");
    for (int j = 0; j < 3; j++) begin
      lf = nx(lf);
      lt <= {1'b0, lf[6:0]};
      rt <= {1'b0, lf[14:8]};
      wcnt(0, 2);
      rd(`TMAS_RD_LOCAL_VAL, {1'b0, lf[6:0]}, "local value");
      rd(`TMAS_RD_REMOTE_VAL, {1'b0, lf[14:8]}, "remote value");
      ara(1'b0);
    end
    rt <= 8'h90;
    wcnt(0, 2);
    chk("alarm on low", {7'd0, alrt}, 8'h00);
    rd(`TMAS_RD_STATUS, 8'h08, "status low");
    ara(1'b1);
    chk("alarm held", {7'd0, alrt}, 8'h00);
    rt <= 8'h10;
    last = 8'h10;
    wcnt(0, 2);
    lose_arb();
    chk("alarm kept on loss", {7'd0, alrt}, 8'h00);
    ara(1'b1);
    chk("alarm freed", {7'd0, alrt}, 8'h01);
    under <= 1'b1;
    wcnt(0, 2);
    rd(`TMAS_RD_REMOTE_VAL, `TMAS_UNDER_RANGE_CODE, "under range");
    wr(`TMAS_WR_REMOTE_LOW, 8'h80, 1);
    wcnt(0, 2);
    ara(1'b1);
    chk("short masked", {7'd0, alrt}, 8'h01);
    under <= 1'b0;
    wr(`TMAS_WR_REMOTE_LOW, 8'h00, 1);
    open_f <= 1'b1;
    wcnt(0, 2);
    rd(`TMAS_RD_STATUS, 8'h04, "status open");
    open_f <= 1'b0;
    wcnt(0, 2);
    ara(1'b1);
    wcnt(1, 1);
    a0 = nabort;
    sleep_n <= 1'b0;
    rt <= 8'h33;
    hc(20);
    chk("aborts", 8'(nabort - a0), 8'h01);
    chk("pin standby", {7'd0, sleep_request_n}, 8'h01);
    rd(`TMAS_RD_REMOTE_VAL, last, "value kept");
    a0 = nstart;
    wr(`TMAS_WR_ONE_SHOT, 8'h00, 1);
    hc(200);
    chk("pin starts", 8'(nstart - a0), 8'h00);
    sleep_n <= 1'b1;
    wr(`TMAS_WR_CONFIG, 8'h40, 1);
    hc(100);
    chk("soft standby", {7'd0, sleep_request_n}, 8'h01);
    rd(`TMAS_RD_CONFIG, 8'h40, "config");
    lf = nx(lf);
    rt <= {1'b0, lf[6:0]};
    a0 = ndone;
    wr(`TMAS_WR_ONE_SHOT, lf[15:8], 1);
    for (int i = 0; i < 4000 && ndone == a0; i++) hc(1);
    hc(300);
    chk("one shot", 8'(ndone - a0), 8'h01);
    rd(`TMAS_RD_REMOTE_VAL, {1'b0, lf[6:0]}, "one shot value");
    report_and_stop();
  end
endmodule // tmas_monitor_test
bind tmas_monitor tmas_monitor_chk #(.CONV_GAP(CONV_GAP)) u_tmas_monitor_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .scl_i(scl_i), .sda_o(sda_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o), .sleep_request_n_i(sleep_request_n_i),
  .open_fault_i(open_fault_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
  .standby_o(standby_o));
`default_nettype wire
